// file: logic/spgc_link_if.sv
// serial front-end to frame decoder carrier
`timescale 1ns/1ns
interface spgc_link_if;
  logic sck_rise;
  logic sck_fall;
  logic cs_act;
  logic byte_valid;
  logic [7:0] rx_byte;
  modport rx (
    output sck_rise,
    output sck_fall,
    output cs_act,
    output byte_valid,
    output rx_byte
  );
  modport core (
    input sck_rise,
    input sck_fall,
    input cs_act,
    input byte_valid,
    input rx_byte
  );
endinterface : spgc_link_if

// file: logic/spgc_pkg.sv
// shared constants for the sector protection and global lock logic
package spgc_pkg;
  // ****************************************
  // command opcodes
  // ****************************************
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_READ_SECT_PROT = 8'h3c;
  // ****************************************
  // status byte layout
  // ****************************************
  localparam int SR_LOCK_POS = 7;
  localparam int SR_WP_POS = 4;
  localparam int SR_SWP_LSB = 2;
  localparam int SR_GLOB_LSB = 2;
  localparam int SR_GLOB_W = 4;
  localparam logic [3:0] GLOB_UNPROT_PAT = 4'h0;
  localparam logic [3:0] GLOB_PROT_PAT = 4'hf;
  // ****************************************
  // summary codes and read-back patterns
  // ****************************************
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL = 2'h3;
  localparam logic [7:0] SPR_BYTE_PROT = 8'hff;
  localparam logic [7:0] SPR_BYTE_UNPROT = 8'h00;
  // ****************************************
  // reset values and address framing
  // ****************************************
  localparam logic LOCK_RST = 1'b0;
  localparam logic SECT_PROT_RST = 1'b1;
  localparam int ADDR_BYTES = 3;
  localparam int SECT_ADDR_LSB = 16;
  // ****************************************
  // frame decoder states
  // ****************************************
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_WSR_DATA,
    ST_SPR_OUT,
    ST_SR_OUT,
    ST_IGNORE
  } spgc_state_t;
endpackage : spgc_pkg

// file: logic/spgc_sector_bits.sv
// per-sector protection flags with global set and clear
`timescale 1ns/1ns
module spgc_sector_bits #(
  parameter int NUM_SECT = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic glob_prot,
  input wire logic glob_unprot,
  output logic [NUM_SECT-1:0] prot_bits
);
  import spgc_pkg::*;
  // ****************************************
  // one flag per sector
  // ****************************************
  // sectors come up protected so power-up is safe by default
  for (genvar i = 0; i < NUM_SECT; i++) begin : g_sect
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        prot_bits[i] <= SECT_PROT_RST;
      end else if (glob_prot) begin
        prot_bits[i] <= 1'b1;
      end else if (glob_unprot) begin
        prot_bits[i] <= 1'b0;
      end
    end
  end
endmodule : spgc_sector_bits

// file: logic/spgc_shift_rx.sv
// serial input sampler and byte assembler
`timescale 1ns/1ns
module spgc_shift_rx (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  spgc_link_if.rx ln
);
  import spgc_pkg::*;
  logic sck_d1_reg;
  logic sck_d2_reg;
  logic cs_n_d1_reg;
  logic si_d1_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  // ****************************************
  // pin delay line and edge detection
  // ****************************************
  // one delay stage keeps si aligned with the detected clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_d1_reg <= 1'b0;
      sck_d2_reg <= 1'b0;
      cs_n_d1_reg <= 1'b1;
      si_d1_reg <= 1'b0;
    end else begin
      sck_d1_reg <= sck;
      sck_d2_reg <= sck_d1_reg;
      cs_n_d1_reg <= cs_n;
      si_d1_reg <= si;
    end
  end
  assign ln.sck_rise = sck_d1_reg & ~sck_d2_reg & ~cs_n_d1_reg;
  assign ln.sck_fall = ~sck_d1_reg & sck_d2_reg & ~cs_n_d1_reg;
  assign ln.cs_act = ~cs_n_d1_reg;
  // ****************************************
  // msb-first byte assembly on rising edges
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst || cs_n_d1_reg) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      ln.byte_valid <= 1'b0;
      ln.rx_byte <= 8'h00;
    end else begin
      ln.byte_valid <= 1'b0;
      if (ln.sck_rise) begin // R18
        shift_reg <= {shift_reg[5:0], si_d1_reg};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          ln.byte_valid <= 1'b1;
          ln.rx_byte <= {shift_reg, si_d1_reg};
        end
      end
    end
  end
endmodule : spgc_shift_rx

// file: logic/spgc_top.sv
// sector protection lock, global protect decode and protection read-back
`timescale 1ns/1ns
// Overview of operation
// [R1] unlocked, status write 00h clears all sector flags, lock stays 0
// [R2] unlocked, status write 7Fh sets all sector flags, lock stays 0
// [R3] unlocked, status write FFh sets all sector flags and the lock
// [R4] write 0Fh clears lock without global change when write-protect pin high
// [R5] write F0h sets lock, sector flags untouched
// [R6] only bit 7 is stored; bits 5..2 are decoded only
// [R7] status read bits 4..2 show pin level and protection summary
// [R8] unlocked: bits 5..2 all 0 unprotect, all 1 protect, else nothing
// [R9] pin high and locked: no global action, lock may clear
// [R10] host clears lock first, then writes again for global action
// [R11] host sends 3Ch then three address bytes inside the sector
// [R12] after address, output repeats FFh if protected, 00h if not
// [R13] chip select release ends read and floats output, even mid-byte
// [R14] protection read-back ignores the write-protect pin
// [R15] summary shows all, some or none of the sectors protected
// [R16] pin low and locked: status writes are ignored entirely
// [R17] setting the lock may carry a global protect or unprotect
// [R18] msb first, sample on rising clock, shift out on falling
module spgc_top
  import spgc_pkg::*;
#(
  parameter int NUM_SECT = 4,
  parameter int SECT_W = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic protect_regs_lock_bit,
  output logic [1:0] sw_protect_summary,
  output logic [NUM_SECT-1:0] sect_prot
);
  import spgc_pkg::*;

  spgc_link_if ln ();
  spgc_state_t state_reg;
  logic [1:0] addr_cnt_reg;
  logic [8*ADDR_BYTES-1:0] addr_reg;
  logic [2:0] out_idx_reg;
  logic so_reg;
  logic so_oe_reg;
  logic lock_reg;
  logic [1:0] swp_reg;
  logic [NUM_SECT-1:0] prot_bits;
  logic wsr_go;
  logic hw_locked;
  logic [3:0] glob_field;
  logic glob_prot;
  logic glob_unprot;
  logic [SECT_W-1:0] sect_sel;
  logic sel_prot;
  logic [1:0] swp_next;
  logic [7:0] sr_byte;

  // ****************************************
  // submodules
  // ****************************************
  spgc_shift_rx u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .ln(ln.rx)
  );

  spgc_sector_bits #(
    .NUM_SECT(NUM_SECT)
  ) u_sect (
    .clk(clk),
    .sys_rst(sys_rst),
    .glob_prot(glob_prot),
    .glob_unprot(glob_unprot),
    .prot_bits(prot_bits)
  );

  // ****************************************
  // status write decode
  // ****************************************
  // write-protect pin is active low: hardware lock needs pin low and lock set
  assign hw_locked = lock_reg & ~wp_n; // R16
  assign wsr_go = ln.byte_valid & (state_reg == ST_WSR_DATA) & ~hw_locked;
  assign glob_field = ln.rx_byte[SR_GLOB_LSB +: SR_GLOB_W]; // R6
  // globals only while the lock is clear before this write
  assign glob_prot = wsr_go & ~lock_reg & (glob_field == GLOB_PROT_PAT); // R8 R2 R3 R17
  assign glob_unprot = wsr_go & ~lock_reg & (glob_field == GLOB_UNPROT_PAT); // R8 R1 R17

  // lock bit: the only stored status bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_reg <= LOCK_RST;
    end else if (wsr_go) begin
      lock_reg <= ln.rx_byte[SR_LOCK_POS]; // R6 R4 R5 R9
    end
  end

  // ****************************************
  // protection summary and read-back sources
  // ****************************************
  assign swp_next = (&prot_bits) ? SWP_ALL : ((|prot_bits) ? SWP_SOME : SWP_NONE); // R15
  assign sect_sel = addr_reg[SECT_ADDR_LSB +: SECT_W];
  assign sel_prot = prot_bits[sect_sel]; // R14
  // reserved bits read zero; bits 4..2 are live, never the written value
  assign sr_byte = {lock_reg, 2'b00, wp_n, swp_reg, 2'b00}; // R7

  // summary registered so the top outputs come from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      swp_reg <= SWP_NONE;
    end else begin
      swp_reg <= swp_next;
    end
  end

  // ****************************************
  // frame decoder
  // ****************************************
  // a released chip select always returns to opcode hunting
  always_ff @(posedge clk) begin
    if (sys_rst || !ln.cs_act) begin
      state_reg <= ST_OPCODE;
    end else if (ln.byte_valid) begin
      case (state_reg)
        ST_OPCODE: begin
          case (ln.rx_byte)
            OP_WRITE_STATUS: begin
              state_reg <= ST_WSR_DATA;
            end
            OP_READ_STATUS: begin
              state_reg <= ST_SR_OUT;
            end
            OP_READ_SECT_PROT: begin
              state_reg <= ST_ADDR; // R11
            end
            default: begin
              state_reg <= ST_IGNORE;
            end
          endcase
        end
        ST_ADDR: begin
          if (addr_cnt_reg == 2'(ADDR_BYTES - 1)) begin
            state_reg <= ST_SPR_OUT; // R11
          end
        end
        ST_WSR_DATA: begin
          // further bytes of a status write are dropped
          state_reg <= ST_IGNORE;
        end
        ST_SPR_OUT: begin
          state_reg <= ST_SPR_OUT;
        end
        ST_SR_OUT: begin
          state_reg <= ST_SR_OUT;
        end
        ST_IGNORE: begin
          state_reg <= ST_IGNORE;
        end
        default: begin
          state_reg <= ST_IGNORE;
        end
      endcase
    end
  end

  // address byte capture, msb byte first
  always_ff @(posedge clk) begin
    if (sys_rst || !ln.cs_act) begin
      addr_cnt_reg <= 2'h0;
    end else if (ln.byte_valid && state_reg == ST_ADDR) begin
      addr_cnt_reg <= addr_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_reg <= '0;
    end else if (ln.byte_valid && state_reg == ST_ADDR) begin
      addr_reg <= {addr_reg[8*ADDR_BYTES-9:0], ln.rx_byte}; // R18
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  // every bit of the repeating pattern equals the sector flag, so no byte
  // shifter is needed for the protection read
  always_ff @(posedge clk) begin
    if (sys_rst || !ln.cs_act) begin
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0; // R13
      out_idx_reg <= 3'h7;
    end else if (ln.sck_fall) begin // R18
      case (state_reg)
        ST_SPR_OUT: begin
          so_reg <= sel_prot ? SPR_BYTE_PROT[out_idx_reg] : SPR_BYTE_UNPROT[out_idx_reg]; // R12
          so_oe_reg <= 1'b1;
          out_idx_reg <= out_idx_reg - 3'h1;
        end
        ST_SR_OUT: begin
          so_reg <= sr_byte[out_idx_reg]; // R7
          so_oe_reg <= 1'b1;
          out_idx_reg <= out_idx_reg - 3'h1;
        end
        default: begin
          so_reg <= 1'b0;
          so_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign so = so_reg;
  assign so_oe = so_oe_reg;
  assign protect_regs_lock_bit = lock_reg;
  assign sw_protect_summary = swp_reg;
  assign sect_prot = prot_bits;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_GLOB_UNPROT: assert property ( // R1
    wsr_go && !lock_reg && ln.rx_byte == 8'h00 |=> prot_bits == '0 && !lock_reg
  ) else $error("status write 00h did not unprotect all sectors");

  AST_GLOB_PROT: assert property ( // R2
    wsr_go && !lock_reg && ln.rx_byte == 8'h7f |=> (&prot_bits) && !lock_reg
  ) else $error("status write 7Fh did not protect all sectors");

  AST_PROT_AND_LOCK: assert property ( // R3
    wsr_go && !lock_reg && ln.rx_byte == 8'hff |=> (&prot_bits) && lock_reg
  ) else $error("status write FFh did not protect and lock");

  AST_UNLOCK_ONLY: assert property ( // R4
    ln.byte_valid && state_reg == ST_WSR_DATA && lock_reg && wp_n && ln.rx_byte == 8'h0f
    |=> !lock_reg && $stable(prot_bits)
  ) else $error("status write 0Fh did not just clear the lock");

  AST_LOCK_ONLY: assert property ( // R5
    wsr_go && !lock_reg && ln.rx_byte == 8'hf0 |=> lock_reg && $stable(prot_bits)
  ) else $error("status write F0h changed sector flags");

  AST_LOCK_HOLD: assert property ( // R6
    !wsr_go |=> $stable(lock_reg)
  ) else $error("lock bit changed outside a status write");

  AST_SOFT_LOCK: assert property ( // R9
    ln.byte_valid && state_reg == ST_WSR_DATA && lock_reg && wp_n |=> $stable(prot_bits)
  ) else $error("global action while soft locked");

  AST_HW_LOCK: assert property ( // R16
    ln.byte_valid && state_reg == ST_WSR_DATA && lock_reg && !wp_n
    |=> $stable(lock_reg) && $stable(prot_bits)
  ) else $error("status write took effect while hardware locked");

  AST_SPR_DATA: assert property ( // R12
    state_reg == ST_SPR_OUT && ln.sck_fall && ln.cs_act |=> so_oe_reg && so_reg == $past(sel_prot)
  ) else $error("protection read bit does not match sector flag");

  AST_CS_FLOAT: assert property ( // R13
    !ln.cs_act |=> !so_oe_reg ##1 !ln.cs_act || !so_oe_reg
  ) else $error("output still driven after chip select release");

  AST_SWP_ALL: assert property ( // R15
    (&prot_bits) ##1 (&prot_bits) |-> sw_protect_summary == SWP_ALL
  ) else $error("summary does not report all sectors protected");

  AST_SWP_NONE: assert property ( // R15
    (prot_bits == '0) ##1 (prot_bits == '0) |-> sw_protect_summary == SWP_NONE
  ) else $error("summary does not report all sectors unprotected");

  AST_SR_LOCK: assert property ( // R6
    state_reg == ST_SR_OUT && ln.sck_fall && ln.cs_act && out_idx_reg == 3'h7
    |=> so_reg == $past(lock_reg)
  ) else $error("status bit 7 does not show the stored lock");

  AST_SR_SWP: assert property ( // R15
    state_reg == ST_SR_OUT && ln.sck_fall && ln.cs_act && out_idx_reg == 3'h3
    |=> so_reg == $past(swp_reg[1])
  ) else $error("status bit 3 does not show the summary");

  AST_SR_WP: assert property ( // R7
    state_reg == ST_SR_OUT && ln.sck_fall && ln.cs_act && out_idx_reg == 3'h4
    |=> so_reg == $past(wp_n)
  ) else $error("status bit 4 does not show the pin level");

  COV_GLOB_PROT: cover property (glob_prot);
  COV_SPR_READ: cover property (state_reg == ST_SPR_OUT && so_oe_reg && so_reg);
  COV_SR_READ: cover property (state_reg == ST_SR_OUT && so_oe_reg);
  COV_HW_IGNORE: cover property (ln.byte_valid && state_reg == ST_WSR_DATA && hw_locked);
endmodule : spgc_top

// file: sim/spgc_host_model.sv
// serial host model driving chip select, serial clock and data in
`timescale 1ns/1ns
module spgc_host_model (
  input wire logic clk,
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // each sck phase lasts 4 clk, two above the 2 clk the sampler needs
  localparam int HALF_CLK = 4;
  // ****************************************
  // idle levels
  // ****************************************
  // clock stands low between frames, so no stray edges reach the device
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // ****************************************
  // frame and bit tasks
  // ****************************************
  // every change lands 1 ns after a clk edge, never on it
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk
  task automatic frame_begin();
    wait_clk(1);
    cs_n = 1'b0;
    wait_clk(HALF_CLK);
  endtask : frame_begin
  // may be called mid-byte; data line is flipped so no stale bit is mistaken for data
  task automatic frame_end();
    wait_clk(HALF_CLK);
    cs_n = 1'b1;
    si = ~si;
    wait_clk(HALF_CLK);
  endtask : frame_end
  // msb first; so is taken just before the rise, a full phase after the fall
  task automatic xfer_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      wait_clk(HALF_CLK);
      rx[i] = so;
      sck = 1'b1;
      wait_clk(HALF_CLK);
      sck = 1'b0;
    end
  endtask : xfer_bits
endmodule : spgc_host_model

// file: sim/spgc_tb_top.sv
// self-checking bench for the sector protection and global lock logic
`timescale 1ns/1ns
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("Error at %0t ns: got %h exp %h", $time, (got), (exp)); \
  end \
end
module spgc_tb_top;
  import spgc_pkg::*;
  localparam int CYCLE_LIMIT = 40000;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wp_n = 1'b1;
  logic sck, cs_n, si, so, so_oe, lock;
  logic [1:0] summ;
  logic [3:0] sect;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] rb;
  logic [15:0] rw;
  // ****************************************
  // clock, device and host
  // ****************************************
  always #20 clk = ~clk;
  spgc_top #(.NUM_SECT(4), .SECT_W(2)) i_dut (.clk(clk), .sys_rst(sys_rst), .sck(sck),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .protect_regs_lock_bit(lock),
    .sw_protect_summary(summ), .sect_prot(sect));
  // a floated output reads inverted, so a late enable corrupts the reply
  spgc_host_model i_host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si),
    .so(so_oe ? so : ~so));
  // hang guard: a run past the ceiling is a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      n_fail++;
      stop_test();
    end
  end
  // ****************************************
  // frame helpers
  // ****************************************
  task automatic wsr(input logic [7:0] d);
    i_host.frame_begin();
    i_host.xfer_bits(OP_WRITE_STATUS, 8, rb);
    i_host.xfer_bits(d, 8, rb);
    i_host.frame_end();
  endtask : wsr
  task automatic rd_status(output logic [7:0] s);
    i_host.frame_begin();
    i_host.xfer_bits(OP_READ_STATUS, 8, rb);
    i_host.xfer_bits(8'h00, 8, s);
    i_host.frame_end();
  endtask : rd_status
  // opcode and three address bytes; the frame is left open for the reply bits
  task automatic sect_req(input logic [23:0] a);
    i_host.frame_begin();
    i_host.xfer_bits(OP_READ_SECT_PROT, 8, rb);
    for (int k = 2; k >= 0; k--) begin
      i_host.xfer_bits(a[k*8 +: 8], 8, rb);
    end
  endtask : sect_req
  task automatic rd_sect(input logic [23:0] a, output logic [15:0] d);
    sect_req(a);
    i_host.xfer_bits(8'h00, 8, d[15:8]);
    i_host.xfer_bits(8'h00, 8, d[7:0]);
    i_host.frame_end();
  endtask : rd_sect
  task automatic expect_state(input logic l, input logic [3:0] s);
    `CHK(lock, l)
    `CHK(sect, s)
  endtask : expect_state
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    `CHK(lock, LOCK_RST)
    `CHK(sect, 4'hf)
    `CHK(summ, SWP_ALL)
    `CHK(so_oe, 1'b0)
    $display("test reset done");
  endtask : t_reset
  // only the all-zero and all-one middle fields act; the rest must be inert
  task automatic t_unlocked();
    logic [7:0] pat [6] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h38, 8'h1c};
    wsr(8'h00);
    expect_state(1'b0, 4'h0);
    `CHK(summ, SWP_NONE)
    foreach (pat[i]) begin
      wsr(pat[i]);
      expect_state(1'b0, 4'h0);
    end
    wsr(8'h7f);
    expect_state(1'b0, 4'hf);
    `CHK(summ, SWP_ALL)
    $display("test unlocked done");
  endtask : t_unlocked
  task automatic t_soft_lock();
    wp_n = 1'b1;
    wsr(8'h00);
    wsr(8'hff);
    expect_state(1'b1, 4'hf);
    wsr(8'h80);
    expect_state(1'b1, 4'hf);
    wsr(8'h00);
    expect_state(1'b0, 4'hf);
    wsr(8'h00);
    expect_state(1'b0, 4'h0);
    wsr(8'hf0);
    expect_state(1'b1, 4'h0);
    wsr(8'h0f);
    expect_state(1'b0, 4'h0);
    wsr(8'h7f);
    wsr(8'h80);
    expect_state(1'b1, 4'h0);
    $display("test soft lock done");
  endtask : t_soft_lock
  task automatic t_hard_lock();
    wp_n = 1'b0;
    wsr(8'h0f);
    expect_state(1'b1, 4'h0);
    wsr(8'h7f);
    expect_state(1'b1, 4'h0);
    wp_n = 1'b1;
    wsr(8'h0f);
    expect_state(1'b0, 4'h0);
    $display("test hard lock done");
  endtask : t_hard_lock
  // written middle bits must not read back; pin and summary show instead
  task automatic t_status();
    wsr(8'h3c);
    rd_status(rb);
    `CHK(rb, 8'h1c)
    wp_n = 1'b0;
    rd_status(rb);
    `CHK(rb, 8'h0c)
    wsr(8'hf0);
    rd_status(rb);
    `CHK(rb, 8'h8c)
    wp_n = 1'b1;
    wsr(8'h0f);
    $display("test status done");
  endtask : t_status
  task automatic t_sect_read();
    wp_n = 1'b0;
    rd_sect(24'h02_1234, rw);
    `CHK(rw, {SPR_BYTE_PROT, SPR_BYTE_PROT})
    wp_n = 1'b1;
    wsr(8'h00);
    wp_n = 1'b0;
    rd_sect(24'h03_ffff, rw);
    `CHK(rw, {SPR_BYTE_UNPROT, SPR_BYTE_UNPROT})
    wp_n = 1'b1;
    $display("test sector read done");
  endtask : t_sect_read
  // release mid-byte must float the output and leave state alone
  task automatic t_abort();
    wsr(8'h7f);
    sect_req(24'h01_0000);
    i_host.xfer_bits(8'h00, 3, rb);
    `CHK(rb, 8'he0)
    `CHK(so_oe, 1'b1)
    i_host.frame_end();
    `CHK(so_oe, 1'b0)
    expect_state(1'b0, 4'hf);
    $display("test abort done");
  endtask : t_abort
  // unknown opcodes and bytes past a status write must change nothing
  task automatic t_refused();
    i_host.frame_begin();
    i_host.xfer_bits(8'h02, 8, rb);
    i_host.xfer_bits(8'h00, 8, rb);
    `CHK(so_oe, 1'b0)
    i_host.frame_end();
    expect_state(1'b0, 4'hf);
    i_host.frame_begin();
    i_host.xfer_bits(OP_WRITE_STATUS, 8, rb);
    i_host.xfer_bits(8'h1c, 8, rb);
    i_host.xfer_bits(8'h00, 8, rb);
    i_host.frame_end();
    expect_state(1'b0, 4'hf);
    $display("test refused done");
  endtask : t_refused
  // ****************************************
  // verdict
  // ****************************************
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_unlocked();
    t_soft_lock();
    t_hard_lock();
    t_status();
    t_sect_read();
    t_abort();
    t_refused();
    stop_test();
  end
endmodule : spgc_tb_top
